// [rtl/rsp_pkg.sv]
// Constants and types for the regulator two-wire target port.
// Assumes a 25 MHz system clock and a 30 ns link sampling clock.
package rsp_pkg;

    // Target address and special address patterns
    localparam logic [6:0] OWN_ADDR = 7'h18;
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;

    // Byte framing: bits counted before the acknowledge slot
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;

    // Reset values
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [1:0] LINE_IDLE = 2'h3;

    // Clock periods
    localparam int SYS_PERIOD_NS = 40;
    localparam int LINK_PERIOD_NS = 30;

    // Spike widths that the input filters must suppress
    localparam int SPIKE_FS_NS = 50;
    localparam int SPIKE_HS_NS = 10;

    // Consecutive differing samples before a line is believed, rounded up
    localparam int FILT_FS_RAW = (SPIKE_FS_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int FILT_HS_RAW = (SPIKE_HS_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam logic [1:0] FILT_FS_CYC = (FILT_FS_RAW < 1) ? 2'h1 : 2'(FILT_FS_RAW);
    localparam logic [1:0] FILT_HS_CYC = (FILT_HS_RAW < 1) ? 2'h1 : 2'(FILT_HS_RAW);

    // Link-side protocol states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } rsp_state_e;

endpackage

// [rtl/rsp_target.sv]
// Two-wire serial target port of the regulator: filters, START/STOP
// detection, address match, pointer, byte write and read, high-speed entry.
// Assumes an oversampling link clock near 33 MHz and a register file on
// sys_clk that answers reg_rd_data combinationally from reg_rd_addr.
//
// How it works
// - one bit per clock; data steady high
// - data edges with clock high: START/STOP
// - idle bus rests with both lines high
// - repeated START restarts like plain START
// - after STOP or mismatch, ignore until START
// - ninth bit acknowledges; receiver holds low
// - not-acknowledge leaves data released high
// - port never drives the clock line
// - general call address gets not-acknowledge
// - fixed target address 0x30 write, 0x31 read
// - works from zero up to 3.4MHz
// - power-up and STOP select slow filters
// - high-speed mode uses faster input filters
// - 00001xxx code: not-acknowledge, enter high speed
// - write address with zero direction acknowledged
// - register pointer stored and acknowledged
// - data acknowledged; written at acknowledge rising edge
// - target only, never starts a transfer
`timescale 1ns/1ns
module rsp_target (
    // System side
    input wire logic sys_clk,
    input wire logic reset_n,
    // Link sampling clock
    input wire logic link_clk,
    // Serial pins; clock line is input only
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Register file, system domain
    output logic reg_wr_en,
    output logic [7:0] reg_wr_addr,
    output logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_addr,
    input wire logic [7:0] reg_rd_data,
    output logic hs_mode
);

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] filt;
        logic [1:0] prev;
        logic [1:0][1:0] fcnt;
        rsp_pkg::rsp_state_e st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic rw;
        logic hs;
        logic [7:0] ptr;
        logic sda_o;
        logic sda_oe;
        logic wr_tgl;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic fetch_tgl;
        logic [7:0] fetch_addr;
        logic [2:0] rd_sync;
        logic [7:0] pre;
    } rsp_link_s;

    typedef struct packed {
        logic [2:0] wr_sync;
        logic [2:0] fetch_sync;
        logic [1:0] hs_sync;
        logic hs_mode;
        logic reg_wr_en;
        logic [7:0] reg_wr_addr;
        logic [7:0] reg_wr_data;
        logic [7:0] reg_rd_addr;
        logic capture;
        logic rd_tgl;
        logic [7:0] rd_hold;
    } rsp_sys_s;

    rsp_link_s l;
    rsp_link_s next_l;
    rsp_sys_s s;
    rsp_sys_s next_s;

    logic link_rst;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic rd_edge;
    logic [1:0] need;

    assign link_rst = !l.rst_sync[1];
    // Edges are taken only from filtered lines
    assign scl_rise = l.filt[0] & ~l.prev[0];
    assign scl_fall = ~l.filt[0] & l.prev[0];
    // A data edge with the clock high both before and after is a condition
    assign start_ev = l.filt[0] & l.prev[0] & l.prev[1] & ~l.filt[1];
    assign stop_ev = l.filt[0] & l.prev[0] & ~l.prev[1] & l.filt[1];
    assign rd_edge = l.rd_sync[2] ^ l.rd_sync[1];
    assign need = l.hs ? rsp_pkg::FILT_HS_CYC : rsp_pkg::FILT_FS_CYC;

    always_comb begin
        next_l = l;
        next_l.rst_sync = {l.rst_sync[0], reset_n};
        next_l.s1 = {sda_i, scl_i};
        next_l.s2 = l.s1;
        next_l.prev = l.filt;
        next_l.rd_sync = {l.rd_sync[1:0], s.rd_tgl};
        // A line changes only after the new level held for the filter span
        for (int i = 0; i < 2; i++) begin
            if (l.s2[i] != l.filt[i]) begin
                if (l.fcnt[i] + 2'h1 >= need) begin
                    next_l.filt[i] = l.s2[i];
                    next_l.fcnt[i] = 2'h0;
                end else begin
                    next_l.fcnt[i] = l.fcnt[i] + 2'h1;
                end
            end else begin
                next_l.fcnt[i] = 2'h0;
            end
        end
        // Prefetched read byte arrives from the system side
        if (rd_edge) begin
            next_l.pre = s.rd_hold;
        end
        if (stop_ev) begin
            next_l.st = rsp_pkg::ST_IDLE;
            next_l.hs = 1'b0;
            next_l.sda_oe = 1'b0;
        end else if (start_ev) begin
            // Repeated START takes the same path as a first START
            next_l.st = rsp_pkg::ST_ADDR;
            next_l.cnt = rsp_pkg::BIT_CNT_RST;
            next_l.sda_oe = 1'b0;
        end else begin
            unique case (l.st)
                rsp_pkg::ST_IDLE: begin
                    // Clock activity is ignored until a START
                    next_l.sda_oe = 1'b0;
                end
                rsp_pkg::ST_ADDR, rsp_pkg::ST_PTR, rsp_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        next_l.shreg = {l.shreg[6:0], l.filt[1]};
                        next_l.cnt = l.cnt + 4'h1;
                    end else if (scl_fall && l.cnt == rsp_pkg::BIT_LAST) begin
                        next_l.cnt = rsp_pkg::BIT_CNT_RST;
                        if (l.st == rsp_pkg::ST_ADDR) begin
                            if (l.shreg[7:1] == rsp_pkg::OWN_ADDR) begin
                                next_l.sda_oe = 1'b1;
                                next_l.rw = l.shreg[0];
                                next_l.st = rsp_pkg::ST_ADDR_ACK;
                            end else begin
                                // General call and strangers are left unanswered
                                next_l.st = rsp_pkg::ST_IDLE;
                                if (l.shreg[7:3] == rsp_pkg::HS_CODE_TOP) begin
                                    next_l.hs = 1'b1;
                                end
                            end
                        end else if (l.st == rsp_pkg::ST_PTR) begin
                            next_l.ptr = l.shreg;
                            next_l.fetch_addr = l.shreg;
                            next_l.fetch_tgl = ~l.fetch_tgl;
                            next_l.sda_oe = 1'b1;
                            next_l.st = rsp_pkg::ST_PTR_ACK;
                        end else begin
                            next_l.wr_addr = l.ptr;
                            next_l.wr_data = l.shreg;
                            next_l.sda_oe = 1'b1;
                            next_l.st = rsp_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                rsp_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (l.rw) begin
                            next_l.tx = l.pre;
                            next_l.sda_oe = ~l.pre[7];
                            next_l.ptr = l.ptr + 8'h01;
                            next_l.fetch_addr = l.ptr + 8'h01;
                            next_l.fetch_tgl = ~l.fetch_tgl;
                            next_l.st = rsp_pkg::ST_RDATA;
                        end else begin
                            next_l.sda_oe = 1'b0;
                            next_l.st = rsp_pkg::ST_PTR;
                        end
                    end
                end
                rsp_pkg::ST_PTR_ACK: begin
                    if (scl_fall) begin
                        next_l.sda_oe = 1'b0;
                        next_l.st = rsp_pkg::ST_WDATA;
                    end
                end
                rsp_pkg::ST_WDATA_ACK: begin
                    // Register takes the byte at the acknowledge rising edge
                    if (scl_rise) begin
                        next_l.wr_tgl = ~l.wr_tgl;
                        next_l.ptr = l.ptr + 8'h01;
                    end else if (scl_fall) begin
                        next_l.sda_oe = 1'b0;
                        next_l.st = rsp_pkg::ST_WDATA;
                    end
                end
                rsp_pkg::ST_RDATA: begin
                    // Data changes only on falling clock edges
                    if (scl_rise) begin
                        next_l.cnt = l.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (l.cnt == rsp_pkg::BIT_LAST) begin
                            next_l.cnt = rsp_pkg::BIT_CNT_RST;
                            next_l.sda_oe = 1'b0;
                            next_l.st = rsp_pkg::ST_RDATA_ACK;
                        end else begin
                            next_l.tx = {l.tx[6:0], 1'b0};
                            next_l.sda_oe = ~l.tx[6];
                        end
                    end
                end
                rsp_pkg::ST_RDATA_ACK: begin
                    if (scl_rise && l.filt[1]) begin
                        next_l.st = rsp_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        next_l.tx = l.pre;
                        next_l.sda_oe = ~l.pre[7];
                        next_l.ptr = l.ptr + 8'h01;
                        next_l.fetch_addr = l.ptr + 8'h01;
                        next_l.fetch_tgl = ~l.fetch_tgl;
                        next_l.st = rsp_pkg::ST_RDATA;
                    end
                end
            endcase
        end
        // Pin drives only low; no clock pin output exists at all
        next_l.sda_o = 1'b0;
        if (link_rst) begin
            next_l = '0;
            next_l.rst_sync = {l.rst_sync[0], reset_n};
            // Lines are assumed released so no false START at release
            next_l.filt = rsp_pkg::LINE_IDLE;
            next_l.prev = rsp_pkg::LINE_IDLE;
            next_l.s1 = rsp_pkg::LINE_IDLE;
            next_l.s2 = rsp_pkg::LINE_IDLE;
            next_l.ptr = rsp_pkg::PTR_RST;
            next_l.st = rsp_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge link_clk) begin
        l <= next_l;
    end

    // System side: held words are stable a whole byte after each toggle
    always_comb begin
        next_s = s;
        next_s.wr_sync = {s.wr_sync[1:0], l.wr_tgl};
        next_s.fetch_sync = {s.fetch_sync[1:0], l.fetch_tgl};
        next_s.hs_sync = {s.hs_sync[0], l.hs};
        next_s.hs_mode = s.hs_sync[1];
        next_s.reg_wr_en = s.wr_sync[2] ^ s.wr_sync[1];
        if (s.wr_sync[2] ^ s.wr_sync[1]) begin
            next_s.reg_wr_addr = l.wr_addr;
            next_s.reg_wr_data = l.wr_data;
        end
        next_s.capture = s.fetch_sync[2] ^ s.fetch_sync[1];
        if (s.fetch_sync[2] ^ s.fetch_sync[1]) begin
            next_s.reg_rd_addr = l.fetch_addr;
        end
        if (s.capture) begin
            next_s.rd_hold = reg_rd_data;
            next_s.rd_tgl = ~s.rd_tgl;
        end
        if (!reset_n) begin
            next_s = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    assign sda_o = l.sda_o;
    assign sda_oe = l.sda_oe;
    assign reg_wr_en = s.reg_wr_en;
    assign reg_wr_addr = s.reg_wr_addr;
    assign reg_wr_data = s.reg_wr_data;
    assign reg_rd_addr = s.reg_rd_addr;
    assign hs_mode = s.hs_mode;

    // Checks on the link side

    property p_steady_high;
        @(posedge link_clk) disable iff (link_rst)
        l.filt[0] && l.prev[0] && !start_ev && !stop_ev |=> $stable(l.sda_oe);
    endproperty
    a_steady_high: assert property (p_steady_high)
        else $error("data drive changed while clock high");

    property p_start_restarts;
        @(posedge link_clk) disable iff (link_rst)
        start_ev && !stop_ev |=> l.st == rsp_pkg::ST_ADDR && l.cnt == 4'h0 && !l.sda_oe;
    endproperty
    a_start_restarts: assert property (p_start_restarts)
        else $error("START did not restart address reception");

    property p_stop_slow;
        @(posedge link_clk) disable iff (link_rst)
        stop_ev |=> l.st == rsp_pkg::ST_IDLE && !l.hs ##2 !l.sda_oe;
    endproperty
    a_stop_slow: assert property (p_stop_slow)
        else $error("STOP left high-speed filters or bus drive");

    property p_idle_quiet;
        @(posedge link_clk) disable iff (link_rst)
        l.st == rsp_pkg::ST_IDLE && $past(l.st) == rsp_pkg::ST_IDLE |-> !l.sda_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("data driven while ignoring the bus");

    property p_gen_call_nack;
        @(posedge link_clk) disable iff (link_rst)
        l.st == rsp_pkg::ST_ADDR && scl_fall && !start_ev && !stop_ev
            && l.cnt == 4'h8 && l.shreg[7:1] == rsp_pkg::GEN_CALL_ADDR
            |=> !l.sda_oe && l.st == rsp_pkg::ST_IDLE && l.hs == $past(l.hs);
    endproperty
    a_gen_call_nack: assert property (p_gen_call_nack)
        else $error("general call was acknowledged");

    property p_addr_ack;
        @(posedge link_clk) disable iff (link_rst)
        l.st == rsp_pkg::ST_ADDR && scl_fall && !start_ev && !stop_ev
            && l.cnt == rsp_pkg::BIT_LAST && l.shreg[7:1] == rsp_pkg::OWN_ADDR
            |=> l.sda_oe && l.rw == $past(l.shreg[0]);
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("own address not acknowledged");

    property p_hs_entry;
        @(posedge link_clk) disable iff (link_rst)
        l.st == rsp_pkg::ST_ADDR && scl_fall && !start_ev && !stop_ev
            && l.cnt == rsp_pkg::BIT_LAST && l.shreg[7:3] == rsp_pkg::HS_CODE_TOP
            |=> l.hs && !l.sda_oe;
    endproperty
    a_hs_entry: assert property (p_hs_entry)
        else $error("master code did not enter high speed with nack");

    property p_ptr_store;
        @(posedge link_clk) disable iff (link_rst)
        l.st == rsp_pkg::ST_PTR && scl_fall && !start_ev && !stop_ev && l.cnt == 4'h8
            |=> l.ptr == $past(l.shreg) && l.sda_oe && l.st == rsp_pkg::ST_PTR_ACK;
    endproperty
    a_ptr_store: assert property (p_ptr_store)
        else $error("pointer not stored and acknowledged");

    property p_write_at_rise;
        @(posedge link_clk) disable iff (link_rst)
        l.st == rsp_pkg::ST_WDATA_ACK && scl_rise && !start_ev && !stop_ev
            |=> l.wr_tgl != $past(l.wr_tgl) && l.sda_oe;
    endproperty
    a_write_at_rise: assert property (p_write_at_rise)
        else $error("write not issued at acknowledge rising edge");

    property p_filter_span;
        @(posedge link_clk) disable iff (link_rst)
        !l.hs && !$past(l.hs) && $changed(l.filt[1])
            |-> $past(l.s2[1], 1) == l.filt[1] && $past(l.s2[1], 2) == l.filt[1];
    endproperty
    a_filter_span: assert property (p_filter_span)
        else $error("data line passed filter too early");

    // Check on the system side

    property p_wr_pulse;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(s.wr_sync[2] ^ s.wr_sync[1]) |=> reg_wr_en ##1 !reg_wr_en;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("register write strobe not a single pulse");

    c_write: cover property (@(posedge link_clk) disable iff (link_rst)
        l.st == rsp_pkg::ST_WDATA_ACK && scl_rise);
    c_read: cover property (@(posedge link_clk) disable iff (link_rst)
        l.st == rsp_pkg::ST_RDATA_ACK && scl_fall);
    c_hs: cover property (@(posedge link_clk) disable iff (link_rst) $rose(l.hs));
    c_repeat_start: cover property (@(posedge link_clk) disable iff (link_rst)
        start_ev && l.st == rsp_pkg::ST_PTR);

endmodule

// [verification/rsp_bus_ctrl.sv]
// Behavioural two-wire bus controller standing on the far side of the port.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ns
module rsp_bus_ctrl (
    // Open-drain drive, high pulls the line low
    output logic scl_pull,
    output logic sda_pull,
    // Resolved data line
    input wire logic sda_line
);
    // Half clock period in ns; the bench shortens it for high speed
    int half = 300;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    task automatic start();
        sda_pull = 1'b1;
        #(half);
        scl_pull = 1'b1;
    endtask

    // Keeps the bus instead of stopping, so filters stay as they are
    task automatic restart();
        #(half / 2);
        sda_pull = 1'b0;
        #(half / 2);
        scl_pull = 1'b0;
        #(half);
        sda_pull = 1'b1;
        #(half);
        scl_pull = 1'b1;
    endtask

    task automatic stop();
        #(half / 2);
        sda_pull = 1'b1;
        #(half / 2);
        scl_pull = 1'b0;
        #(half);
        sda_pull = 1'b0;
        #(half);
    endtask

    // Data moves mid-low only, never beside a clock edge
    task automatic bit_out(input logic b, input logic glitch);
        #(half / 2);
        sda_pull = ~b;
        #(half / 2);
        scl_pull = 1'b0;
        if (glitch) begin
            // A 20 ns dip is shorter than two link samples
            #(half / 2);
            scl_pull = 1'b1;
            #20;
            scl_pull = 1'b0;
            #(half / 2 - 20);
        end else begin
            #(half);
        end
        scl_pull = 1'b1;
    endtask

    task automatic bit_in(output logic b);
        #(half / 2);
        sda_pull = 1'b0;
        #(half / 2);
        scl_pull = 1'b0;
        #(half / 2);
        b = sda_line;
        #(half / 2);
        scl_pull = 1'b1;
    endtask

    task automatic write_byte(input logic [7:0] d, input logic glitch, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i], glitch && i == 7);
        end
        bit_in(ack);
    endtask

    // Zero in mack asks for more; a one closes the read
    task automatic read_byte(input logic mack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(mack, 1'b0);
    endtask
endmodule

// [verification/regulator_i2c_slave_port_bench.sv]
// Self-checking bench for the two-wire target port with a model register file.
// Assumes rsp_bus_ctrl as bus controller and pull-ups on both lines.
`timescale 1ns/1ns
module regulator_i2c_slave_port_bench;
    logic sys_clk;
    logic link_clk;
    logic reset_n;
    logic scl_pull;
    logic sda_pull;
    logic sda_o;
    logic sda_oe;
    logic reg_wr_en;
    logic hs_mode;
    logic ack;
    logic [7:0] reg_wr_addr;
    logic [7:0] reg_wr_data;
    logic [7:0] reg_rd_addr;
    logic [7:0] rd;
    logic [7:0] regs [0:255];
    wire logic scl_line;
    wire logic sda_line;
    wire logic [7:0] reg_rd_data;
    int wr_count = 0;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    assign scl_line = ~scl_pull;
    assign sda_line = ~(sda_pull | sda_oe);
    assign reg_rd_data = regs[reg_rd_addr];

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end

    rsp_target uut (.sys_clk(sys_clk), .reset_n(reset_n), .link_clk(link_clk),
        .scl_i(scl_line), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .hs_mode(hs_mode));

    rsp_bus_ctrl ctrl (.scl_pull(scl_pull), .sda_pull(sda_pull), .sda_line(sda_line));

    always @(posedge sys_clk) begin
        if (reg_wr_en === 1'b1) begin
            regs[reg_wr_addr] <= reg_wr_data;
            wr_count <= wr_count + 1;
        end
    end

    task automatic check1(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_write();
        int base;
        base = wr_count;
        step(1);
        ctrl.start();
        ctrl.write_byte(8'h30, 1'b0, ack);
        check1(ack, 1'b0, "write address ack");
        ctrl.write_byte(8'h05, 1'b0, ack);
        check1(ack, 1'b0, "pointer ack");
        ctrl.write_byte(8'ha5, 1'b0, ack);
        check1(ack, 1'b0, "data ack");
        ctrl.write_byte(8'h3c, 1'b0, ack);
        check1(ack, 1'b0, "second data ack");
        ctrl.stop();
        step(10);
        check8(regs[8'h05], 8'ha5, "first register");
        check8(regs[8'h06], 8'h3c, "next register");
        check1(wr_count - base == 2, 1'b1, "write pulse count");
        check1(sda_oe, 1'b0, "data line idle");
        check1(sda_o, 1'b0, "data pin pulls only low");
    endtask

    task automatic t_read();
        step(1);
        ctrl.start();
        ctrl.write_byte(8'h30, 1'b0, ack);
        ctrl.write_byte(8'h05, 1'b0, ack);
        check1(ack, 1'b0, "pointer ack");
        ctrl.restart();
        ctrl.write_byte(8'h31, 1'b0, ack);
        check1(ack, 1'b0, "read address ack");
        ctrl.read_byte(1'b0, rd);
        check8(rd, 8'ha5, "first read byte");
        ctrl.read_byte(1'b1, rd);
        check8(rd, 8'h3c, "last read byte");
        ctrl.stop();
        check1(sda_oe, 1'b0, "released after read");
    endtask

    task automatic t_refuse();
        int base;
        base = wr_count;
        step(1);
        ctrl.start();
        ctrl.write_byte(8'h00, 1'b0, ack);
        check1(ack, 1'b1, "general call nack");
        ctrl.write_byte(8'h30, 1'b0, ack);
        check1(ack, 1'b1, "ignored without start");
        ctrl.stop();
        ctrl.start();
        ctrl.write_byte(8'h32, 1'b0, ack);
        check1(ack, 1'b1, "foreign address nack");
        ctrl.write_byte(8'h30, 1'b0, ack);
        check1(ack, 1'b1, "ignored after mismatch");
        ctrl.stop();
        ctrl.write_byte(8'h30, 1'b0, ack);
        check1(ack, 1'b1, "ignored after stop");
        // Return the bus to idle so the next START is seen with the clock high
        ctrl.stop();
        ctrl.start();
        ctrl.write_byte(8'h30, 1'b0, ack);
        check1(ack, 1'b0, "retry after nack");
        ctrl.stop();
        step(10);
        check1(wr_count == base, 1'b1, "no write");
    endtask

    task automatic t_hs();
        step(1);
        check1(hs_mode, 1'b0, "slow filters");
        ctrl.start();
        ctrl.write_byte(8'h0b, 1'b0, ack);
        check1(ack, 1'b1, "master code nack");
        step(4);
        check1(hs_mode, 1'b1, "fast filters");
        ctrl.half = 180;
        ctrl.restart();
        ctrl.write_byte(8'h30, 1'b0, ack);
        check1(ack, 1'b0, "fast address ack");
        ctrl.write_byte(8'h10, 1'b0, ack);
        ctrl.write_byte(8'h77, 1'b0, ack);
        check1(ack, 1'b0, "fast data ack");
        ctrl.stop();
        ctrl.half = 300;
        step(10);
        check1(hs_mode, 1'b0, "filters back after stop");
        check8(regs[8'h10], 8'h77, "fast write");
    endtask

    task automatic t_glitch();
        step(1);
        ctrl.start();
        ctrl.write_byte(8'h30, 1'b0, ack);
        ctrl.write_byte(8'h20, 1'b0, ack);
        ctrl.write_byte(8'h5a, 1'b1, ack);
        check1(ack, 1'b0, "ack despite glitch");
        ctrl.stop();
        step(10);
        check8(regs[8'h20], 8'h5a, "glitch filtered");
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Whole sequence needs about 3100 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 12000) begin
            num_errors++;
            $display("BAD %0t run did not finish", $time);
            results();
        end
    end

    initial begin
        reset_n = 1'b0;
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'h00;
        end
        step(16);
        reset_n = 1'b1;
        step(10);
        t_write();
        t_read();
        t_refuse();
        t_hs();
        t_glitch();
        results();
    end
endmodule
